// ### bench/ida_top_bench.sv
// self-checking bench for the addressing unit
`timescale 1ns/10ps
module ida_top_bench;
  logic        ref_clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [7:0]  mem [4096];
  logic [11:0] p [3];
  logic [7:0]  w;
  logic [3:0]  bank_m;
  logic [7:0]  exp_q [$];
  logic [7:0]  exp_v;
  logic        rd_q = 1'b0;
  int          n_mismatch;
  int          n_compared;
  int          cyc;
  int          i;
  int          j;

  ida_top i_ida_top
  (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // reference model first, then one strobe cycle; reads queue their result
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    logic [7:0]  r;
    logic [11:0] ea;
    logic [1:0]  s;
    logic [2:0]  l;
    s = a[4:3];
    l = a[2:0];
    r = 8'h00;
    if (a < 8'h18 && l < 3'h5)
    begin
      if (l == 3'h3)
        p[s] = p[s] + 12'h001;
      ea = (l == 3'h4) ? p[s] + {4'h0, w} : p[s];
      if (wr)
        mem[ea] = d;
      r = mem[ea];
      if (l == 3'h1)
        p[s] = p[s] + 12'h001;
      if (l == 3'h2)
        p[s] = p[s] - 12'h001;
    end
    else if (a < 8'h18 && l == 3'h5)
    begin
      if (wr)
        p[s][11:8] = d[3:0];
      r = {4'h0, p[s][11:8]};
    end
    else if (a < 8'h18 && l == 3'h6)
    begin
      if (wr)
        p[s][7:0] = d;
      r = p[s][7:0];
    end
    else if (a == 8'h07)
    begin
      if (wr)
        w = d;
      r = w;
    end
    else if (a == 8'h0F)
    begin
      if (wr)
        bank_m = d[3:0];
      r = {4'h0, bank_m};
    end
    if (!wr)
      exp_q.push_back(r);
    reg_wr    <= wr;
    reg_rd    <= !wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (rd_q)
    begin
      exp_v = exp_q.pop_front();
      n_compared++;
      if (reg_rdata !== exp_v)
      begin
        n_mismatch++;
        $display("unexpected at %0t: got %h expected %h", $time, reg_rdata, exp_v);
      end
    end
    rd_q <= reg_rd;
    if (cyc > 12000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial
  begin
    resetn    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    w         = 8'h00;
    bank_m    = 4'h0;
    p         = '{3{12'h000}};
    void'($urandom(32'hB0C5352E));
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (i = 5; i < 24; i++)
      if (i % 8 > 4)
        acc(1'b0, 8'(i), 8'h00);
    // fill all memory so every later read has a known value
    for (i = 0; i < 4096; i++)
      acc(1'b1, 8'h01, 8'($urandom));
    for (i = 0; i < 24; i = i + 8)
      for (j = 0; j < 5; j++)
      begin
        acc(1'b0, 8'(i + 6), 8'h00);
        acc(1'b0, 8'(i + j), 8'h00);
        acc(1'b0, 8'(i + 6), 8'h00);
      end
    acc(1'b1, 8'h06, 8'hFF);
    acc(1'b1, 8'h05, 8'h00);
    acc(1'b0, 8'h01, 8'h00);
    acc(1'b0, 8'h05, 8'h00);
    acc(1'b0, 8'h02, 8'h00);
    acc(1'b0, 8'h05, 8'h00);
    acc(1'b1, 8'h07, 8'h00);
    acc(1'b1, 8'h04, 8'h5A);
    acc(1'b0, 8'h00, 8'h00);
    acc(1'b1, 8'h00, 8'hA5);
    acc(1'b0, 8'h00, 8'h00);
    // nonzero working register, so an offset that ignores it lands elsewhere
    acc(1'b1, 8'h07, 8'h03);
    acc(1'b1, 8'h04, 8'h3C);
    acc(1'b1, 8'h06, 8'h02);
    acc(1'b1, 8'h05, 8'h01);
    acc(1'b0, 8'h00, 8'h00);
    // mid-run reset: registers go back to zero, memory keeps its contents
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    w      = 8'h00;
    bank_m = 4'h0;
    p      = '{3{12'h000}};
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (i = 5; i < 24; i++)
      if (i % 8 > 4)
        acc(1'b0, 8'(i), 8'h00);
    repeat (3000) acc(1'($urandom), 8'($urandom_range(31)), 8'($urandom));
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (3) @(posedge ref_clk);
    print_verdict();
  end
endmodule

// ### bench/ida_top_sva.sv
// assertions on the register port of the addressing unit
`timescale 1ns/10ps
module ida_top_sva
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  a_plain_keeps_ptr: assert property (
    rd_at(8'h06) ##1 rd_at(8'h00) ##1 rd_at(8'h06) |=> reg_rdata == $past(reg_rdata, 2))
    else $error("pointer moved");
  a_postinc_bumps_ptr: assert property (
    rd_at(8'h06) ##1 rd_at(8'h01) ##1 rd_at(8'h06) |=> reg_rdata == 8'($past(reg_rdata, 2) + 8'h01))
    else $error("no post increment");
  a_postdec_drops_ptr: assert property (
    rd_at(8'h06) ##1 rd_at(8'h02) ##1 rd_at(8'h06) |=> reg_rdata == 8'($past(reg_rdata, 2) - 8'h01))
    else $error("no post decrement");
  a_preinc_bumps_ptr: assert property (
    rd_at(8'h06) ##1 rd_at(8'h03) ##1 rd_at(8'h06) |=> reg_rdata == 8'($past(reg_rdata, 2) + 8'h01))
    else $error("no pre increment");
  a_offset_zero_work: assert property (
    (reg_wr && reg_addr == 8'h07 && reg_wdata == 8'h00) ##1 wr_at(8'h04) ##1 rd_at(8'h00)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("offset access misplaced");
  a_store_goes_mem: assert property (
    wr_at(8'h00) ##1 rd_at(8'h00) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("indirect store lost");
  a_carry_into_high: assert property (
    (reg_wr && reg_addr == 8'h06 && reg_wdata == 8'hFF)
    ##1 (reg_wr && reg_addr == 8'h05 && reg_wdata[3:0] == 4'h0)
    ##1 rd_at(8'h01) ##1 rd_at(8'h05) |=> reg_rdata == 8'h01) else $error("no carry");
  a_unmapped_reads_zero: assert property (reg_rd && reg_addr > 8'h17 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (rd_at(8'h01));
  cover property (wr_at(8'h07));
  cover property (rd_at(8'h17));
endmodule

bind ida_top ida_top_sva i_ida_top_sva
(
  .ref_clk   (ref_clk),
  .resetn    (resetn),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata)
);

// ### rtl/ida_data_mem.sv
// data memory with registered read port that also carries register reads
`timescale 1ns/10ps
module ida_data_mem
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // access port
  ida_mem_if.mem   port
);

  logic [7:0] mem_r [0:ida_pkg::MEM_DEPTH-1];
  logic [7:0] rdata_r;

  always_ff @(posedge ref_clk)
  begin
    if (port.we)
    begin
      mem_r[port.addr] <= port.wdata;
    end
  end

  // one output flop serves both memory and register reads
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_r <= ida_pkg::RDATA_RESET;
    end
    else if (port.re)
    begin
      rdata_r <= mem_r[port.addr];
    end
    else
    begin
      rdata_r <= port.bypass;
    end
  end

  assign port.rdata = rdata_r;

endmodule

// ### rtl/ida_mem_if.sv
// connection between the addressing unit and its data memory
`timescale 1ns/10ps
interface ida_mem_if;
  logic [11:0] addr;
  logic        we;
  logic [7:0]  wdata;
  logic        re;
  logic [7:0]  bypass;
  logic [7:0]  rdata;

  modport ctrl
  (
    output addr,
    output we,
    output wdata,
    output re,
    output bypass,
    input  rdata
  );

  modport mem
  (
    input  addr,
    input  we,
    input  wdata,
    input  re,
    input  bypass,
    output rdata
  );
endinterface

// ### rtl/ida_pkg.sv
// constants for the indirect data addressing unit
package ida_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned REG_ADDR_W  = 8;
  localparam int unsigned PTR_W       = 12;
  localparam int unsigned PTR_HI_W    = 4;
  localparam int unsigned PTR_LO_W    = 8;
  localparam int unsigned BANK_W      = 4;
  localparam int unsigned NUM_PTR     = 3;
  localparam int unsigned MEM_DEPTH   = 4096;

  // register map: pointer set n occupies offsets n*8 .. n*8+6
  localparam logic [7:0] PTR_SET_STRIDE   = 8'h08;
  localparam logic [2:0] LOC_INDIRECT     = 3'h0;
  localparam logic [2:0] LOC_POST_INC     = 3'h1;
  localparam logic [2:0] LOC_POST_DEC     = 3'h2;
  localparam logic [2:0] LOC_PRE_INC      = 3'h3;
  localparam logic [2:0] LOC_OFFSET       = 3'h4;
  localparam logic [2:0] LOC_PTR_HIGH     = 3'h5;
  localparam logic [2:0] LOC_PTR_LOW      = 3'h6;
  localparam logic [7:0] OFF_WORKING_REG  = 8'h07;
  localparam logic [7:0] OFF_BANK_SELECT  = 8'h0F;

  // reset values
  localparam logic [11:0] PTR_RESET       = 12'h000;
  localparam logic [7:0]  WORKING_RESET   = 8'h00;
  localparam logic [3:0]  BANK_RESET      = 4'h0;
  localparam logic [7:0]  RDATA_RESET     = 8'h00;
endpackage

// ### rtl/ida_top.sv
// indirect data addressing unit: three pointer sets, working and bank registers
//
// Overview of operation
// - The indirect location of each set reads or writes the byte its pointer selects and leaves the pointer alone.
// - The post-increment location uses the current pointer, then adds one to it.
// - The post-decrement location uses the current pointer, then subtracts one from it.
// - The pre-increment location adds one to the pointer first and uses the new value.
// - The offset location addresses memory at the pointer plus the working register.
// - The five access locations hold nothing; every access goes to data memory.
`timescale 1ns/10ps
module ida_top
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output wire logic [7:0] reg_rdata
);

  localparam int unsigned PW = ida_pkg::PTR_W;

  ida_mem_if mem_bus ();

  logic [PW-1:0]  ptr_r      [ida_pkg::NUM_PTR];
  logic [PW-1:0]  ptr_nxt    [ida_pkg::NUM_PTR];
  logic [7:0]     working_r;
  logic [3:0]     bank_r;

  logic [4:0]     set_sel;
  logic [2:0]     loc;
  logic           set_hit;
  logic           virt_hit;
  logic           access;
  logic [PW-1:0]  cur_ptr;
  logic [PW-1:0]  eff_addr;
  logic [7:0]     bypass_val;

  // address decode
  always_comb
  begin
    set_sel  = reg_addr[7:3];
    loc      = reg_addr[2:0];
    set_hit  = (set_sel < 5'(ida_pkg::NUM_PTR));
    virt_hit = set_hit && (loc <= ida_pkg::LOC_OFFSET);
    access   = reg_wr || reg_rd;
    cur_ptr  = set_hit ? ptr_r[set_sel[1:0]] : ida_pkg::PTR_RESET;
  end

  // effective data memory address of a virtual location
  always_comb
  begin
    unique case (loc)
      ida_pkg::LOC_PRE_INC:
        eff_addr = cur_ptr + 12'h001;
      ida_pkg::LOC_OFFSET:
        eff_addr = cur_ptr + {4'h0, working_r};
      default:
        eff_addr = cur_ptr;
    endcase
  end

  // pointer next values; the 12-bit adder carries across both halves
  genvar g;
  generate
    for (g = 0; g < ida_pkg::NUM_PTR; g++)
    begin : g_ptr
      logic sel;
      assign sel = set_hit && (set_sel[1:0] == 2'(g));

      always_comb
      begin
        ptr_nxt[g] = ptr_r[g];
        if (sel && access)
        begin
          unique case (loc)
            ida_pkg::LOC_POST_INC:
              ptr_nxt[g] = ptr_r[g] + 12'h001;
            ida_pkg::LOC_POST_DEC:
              ptr_nxt[g] = ptr_r[g] - 12'h001;
            ida_pkg::LOC_PRE_INC:
              ptr_nxt[g] = ptr_r[g] + 12'h001;
            ida_pkg::LOC_PTR_HIGH:
            begin
              if (reg_wr)
              begin
                ptr_nxt[g] = {reg_wdata[3:0], ptr_r[g][7:0]};
              end
            end
            ida_pkg::LOC_PTR_LOW:
            begin
              if (reg_wr)
              begin
                ptr_nxt[g] = {ptr_r[g][11:8], reg_wdata};
              end
            end
            default:
              ptr_nxt[g] = ptr_r[g];
          endcase
        end
      end

      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          ptr_r[g] <= ida_pkg::PTR_RESET;
        end
        else
        begin
          ptr_r[g] <= ptr_nxt[g];
        end
      end
    end
  endgenerate

  // working register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      working_r <= ida_pkg::WORKING_RESET;
    end
    else if (reg_wr && reg_addr == ida_pkg::OFF_WORKING_REG)
    begin
      working_r <= reg_wdata;
    end
  end

  // bank select, upper nibble unimplemented
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bank_r <= ida_pkg::BANK_RESET;
    end
    else if (reg_wr && reg_addr == ida_pkg::OFF_BANK_SELECT)
    begin
      bank_r <= reg_wdata[3:0];
    end
  end

  // read value of real registers; unmapped offsets read zero
  always_comb
  begin
    bypass_val = 8'h00;
    if (reg_addr == ida_pkg::OFF_WORKING_REG)
    begin
      bypass_val = working_r;
    end
    else if (reg_addr == ida_pkg::OFF_BANK_SELECT)
    begin
      bypass_val = {4'h0, bank_r};
    end
    else if (set_hit && loc == ida_pkg::LOC_PTR_HIGH)
    begin
      bypass_val = {4'h0, cur_ptr[11:8]};
    end
    else if (set_hit && loc == ida_pkg::LOC_PTR_LOW)
    begin
      bypass_val = cur_ptr[7:0];
    end
  end

  // virtual locations have no flops: steer straight to memory
  assign mem_bus.addr   = eff_addr;
  assign mem_bus.we     = reg_wr && virt_hit;
  assign mem_bus.wdata  = reg_wdata;
  assign mem_bus.re     = reg_rd && virt_hit;
  assign mem_bus.bypass = bypass_val;

  ida_data_mem u_mem
  (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .port    (mem_bus.mem)
  );

  // read data flop sits inside the memory so the output comes from a register
  assign reg_rdata = mem_bus.rdata;

endmodule
